// file: dv/gcs_src_model.sv
/* Behavioural clock source for the switch bench.
   Assumes the bench sets run and stop level. */
`timescale 1ns/1ns
`default_nettype none
module gcs_src_model #(
    parameter int HALF_NS = 50
) (
    input wire logic i_run,
    input wire logic i_stop_lvl,
    output logic o_clk
);
    // Stopping at a level models a failed source
    initial begin
        o_clk = 1'b0;
        forever begin
            #HALF_NS;
            o_clk = i_run ? ~o_clk : i_stop_lvl;
        end
    end
endmodule // gcs_src_model
`default_nettype wire

// file: dv/gcs_top_props.sv
/* Checker on the clock switch top ports.
   Assumes the defines header is on the include path. */
`timescale 1ns/1ns
`default_nettype none
`include "gcs_defines.vh"
module gcs_top_props (
    input wire logic I_CLK_SYS,
    input wire logic I_SYS_RST,
    input wire logic I_CLOCK_INPUT_A,
    input wire logic I_CLOCK_INPUT_B,
    input wire logic I_VALID_A,
    input wire logic I_VALID_B,
    input wire logic I_SELECT,
    input wire logic I_BYPASS,
    input wire logic [`GCS_FANOUT-1:0] O_CLK_OUT,
    input wire logic O_ACTIVE_SEL,
    input wire logic O_SWITCHING
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST);
    wire logic pick_in = I_SELECT ? I_CLOCK_INPUT_B : I_CLOCK_INPUT_A;
    wire logic sel_ok = O_ACTIVE_SEL ? I_VALID_B : I_VALID_A;
    wire logic q0 = O_CLK_OUT[0];
    // Bypass kept low long enough that it cannot end a sequence
    sequence s_quiet; (!I_BYPASS)[*5]; endsequence
    sequence s_done; $fell(O_SWITCHING); endsequence
    copies_equal_a: assert property (O_CLK_OUT == {`GCS_FANOUT{q0}})
        else $error("copies differ");
    reset_state_a: assert property (disable iff (1'b0) I_SYS_RST |-> !O_CLK_OUT && !O_ACTIVE_SEL && !O_SWITCHING)
        else $error("reset state wrong");
    switch_bound_a: assert property ($rose(O_SWITCHING) |-> ##[1:400] !O_SWITCHING)
        else $error("switch too long");
    bypass_follow_a: assert property ((I_BYPASS && $stable(I_SELECT) && I_VALID_A && I_VALID_B)[*8]
        |-> q0 == $past(pick_in, 4)) else $error("bypass not following");
    low_before_a: assert property (s_quiet ##0 s_done |-> !q0 && !$past(q0))
        else $error("no low stage");
    sel_commit_a: assert property (s_quiet ##0 s_done |-> $changed(O_ACTIVE_SEL))
        else $error("active not updated");
    hold_invalid_a: assert property ((!sel_ok && !O_SWITCHING && !I_BYPASS)[*6] |-> $stable(q0))
        else $error("output moved");
    switch_start_a: assert property ((I_SELECT != O_ACTIVE_SEL && !I_BYPASS)[*5] |-> O_SWITCHING)
        else $error("no switch started");
endmodule // gcs_top_props
bind gcs_top gcs_top_props u_props (.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST),
    .I_CLOCK_INPUT_A(I_CLOCK_INPUT_A), .I_CLOCK_INPUT_B(I_CLOCK_INPUT_B), .I_VALID_A(I_VALID_A),
    .I_VALID_B(I_VALID_B), .I_SELECT(I_SELECT), .I_BYPASS(I_BYPASS), .O_CLK_OUT(O_CLK_OUT),
    .O_ACTIVE_SEL(O_ACTIVE_SEL), .O_SWITCHING(O_SWITCHING));
`default_nettype wire

// file: dv/tb.sv
/* Bench for the glitchless clock switch.
   Assumes the checker is bound to the top. */
`timescale 1ns/1ns
`default_nettype none
`include "gcs_defines.vh"
module tb;
    logic clk = 0, rst = 0, sel = 0, byp = 0, va = 1, vb = 1;
    logic ra = 1, rb = 1, la = 0, lb = 0;
    wire ca, cb, act, sw;
    wire [`GCS_FANOUT-1:0] q;
    int err_total = 0, n_checks = 0;
    always #5 clk = ~clk;
    // Half periods 50/60 ns keep the ratio below the limit
    gcs_src_model #(.HALF_NS(50)) u_src_a (.i_run(ra), .i_stop_lvl(la), .o_clk(ca));
    gcs_src_model #(.HALF_NS(60)) u_src_b (.i_run(rb), .i_stop_lvl(lb), .o_clk(cb));
    gcs_top u_dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CLOCK_INPUT_A(ca), .I_CLOCK_INPUT_B(cb),
        .I_VALID_A(va), .I_VALID_B(vb), .I_SELECT(sel), .I_BYPASS(byp), .O_CLK_OUT(q),
        .O_ACTIVE_SEL(act), .O_SWITCHING(sw));
    ////////////////////////////////////////////////////////////
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic s, input logic e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s exp %b seen %b", nm, e, s);
        end
    endtask
    task step;
        @(posedge clk);
        #1;
    endtask
    task wait_out(input logic v, output int n);
        n = 0;
        while (q[0] !== v && n < 400) begin
            step;
            n++;
        end
        chk("reached", q[0], v);
    endtask
    task wait_done(output int n);
        n = 0;
        while (sw !== 1'b1 && n < 10) begin
            step;
            n++;
        end
        while (sw !== 1'b0 && n < 400) begin
            step;
            n++;
        end
        chk("settled", sw, 1'b0);
    endtask
    task t_run(input logic s);
        int n;
        @(posedge clk) sel <= s;
        wait_done(n);
        chk("active", act, s);
        chk("bound", n <= 17 * 12 + 4, 1'b1);
        wait_out(1'b1, n);
        wait_out(1'b0, n);
        chk("follows", n < 20, 1'b1);
    endtask
    // Old clock stops at lvl, then switch away from it
    task t_stuck(input logic lvl);
        int n, h;
        logic s;
        s = ~act;
        @(posedge clk) begin
            if (s) begin
                la <= lvl;
                ra <= 1'b0;
            end else begin
                lb <= lvl;
                rb <= 1'b0;
            end
        end
        repeat (100) step;
        chk("held", q[0], lvl);
        @(posedge clk) sel <= s;
        if (lvl) begin
            wait_out(1'b0, h);
            chk("hi phase", h > 6, 1'b1);
        end
        wait_out(1'b1, n);
        if (lvl) chk("lo phase", n > 6, 1'b1);
        chk("stuck act", act, s);
        @(posedge clk) begin
            ra <= 1'b1;
            rb <= 1'b1;
        end
    endtask
    task t_invalid;
        logic v;
        int n;
        @(posedge clk) va <= 1'b0;
        repeat (10) step;
        v = q[0];
        repeat (60) step;
        chk("frozen", q[0], v);
        @(posedge clk) sel <= 1'b1;
        wait_done(n);
        chk("dead old", act, 1'b1);
        @(posedge clk) va <= 1'b1;
    endtask
    task t_bypass;
        // Long enough on both sides of the select change to arm the follow check
        @(posedge clk) byp <= 1'b1;
        repeat (12) step;
        @(posedge clk) sel <= 1'b0;
        repeat (12) step;
        chk("byp act", act, 1'b0);
        chk("byp sw", sw, 1'b0);
        @(posedge clk) byp <= 1'b0;
        repeat (5) step;
    endtask
    initial begin
        // Raised by an edge at time zero so the async reset branches fire
        rst <= 1'b1;
        repeat (6) step;
        chk("rst out", q[0], 1'b0);
        @(posedge clk) rst <= 1'b0;
        repeat (100) step;
        t_run(1'b1);
        t_run(1'b0);
        t_stuck(1'b1);
        t_stuck(1'b0);
        t_invalid;
        t_bypass;
        print_verdict;
    end
    // Whole run needs well under 10k cycles
    initial begin
        #300000;
        err_total++;
        print_verdict;
    end
endmodule // tb
`default_nettype wire

// file: rtl/gcs_defines.vh
/*
 * Constants of the glitchless clock switch: stage lengths, stuck
 * detection window, state codes and fanout width.
 * Assumes inclusion by bare name from the design and bench files.
 */
`ifndef GCS_DEFINES_VH
`define GCS_DEFINES_VH

// Fanout copies of the switched clock
`define GCS_FANOUT 8

// Old-clock pulses still passed before the low stage
`define GCS_STAGE1_PULSES 3'h2
// New-clock pulses held high when leaving a stuck-high clock
`define GCS_HIGH_PULSES 3'h2
// New-clock falling edges held low before following the new clock
`define GCS_LOW_EDGES 3'h2

// System cycles without an edge before an input counts as stuck
`define GCS_STUCK_CYCLES 8'h40

// Sequencer state codes
`define GCS_ST_FOLLOW 2'h0
`define GCS_ST_DRAIN 2'h1
`define GCS_ST_HOLD_HI 2'h2
`define GCS_ST_LOW 2'h3

`endif

// file: rtl/gcs_input_guard.v
/*
 * Fail-safe guard for one clock input: synchronises the oversampled
 * clock and its valid flag, keeps the last valid level, flags edges
 * and a stuck input.
 * Assumes the clock input is sampled well above its own rate.
 */
`timescale 1ns/1ns
`default_nettype none
`include "gcs_defines.vh"

module gcs_input_guard (
    // System
    input wire i_clk,
    input wire i_rst,
    // Raw input side
    input wire i_clk_in,
    input wire i_valid,
    // Guarded view
    output reg o_level,
    output reg o_rise,
    output reg o_fall,
    output reg o_stuck
);

    ////////////////////////////////////////////////////////////////////
    reg meta_clk_ff;
    reg sync_clk_ff;
    reg meta_val_ff;
    reg sync_val_ff;
    reg [7:0] idle_cnt_ff;
    reg [7:0] nxt_idle_cnt;
    reg nxt_level;

    // Two-flop synchronisers; first stage read only by second
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_clk_ff <= 1'b0;
            sync_clk_ff <= 1'b0;
            meta_val_ff <= 1'b0;
            sync_val_ff <= 1'b0;
        end else begin
            meta_clk_ff <= i_clk_in;
            sync_clk_ff <= meta_clk_ff;
            meta_val_ff <= i_valid;
            sync_val_ff <= meta_val_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Level only moves while the input is judged valid
    always @* begin
        nxt_level = sync_val_ff ? sync_clk_ff : o_level;
        nxt_idle_cnt = idle_cnt_ff;
        if (nxt_level != o_level) begin
            nxt_idle_cnt = 8'h00;
        end else if (idle_cnt_ff != `GCS_STUCK_CYCLES) begin
            nxt_idle_cnt = idle_cnt_ff + 8'h01;
        end
    end

    // Degrading but toggling input passes edges through unfiltered
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_level <= 1'b0;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
            o_stuck <= 1'b1;
            idle_cnt_ff <= `GCS_STUCK_CYCLES;
        end else begin
            o_level <= nxt_level;
            o_rise <= nxt_level & ~o_level;
            o_fall <= ~nxt_level & o_level;
            idle_cnt_ff <= nxt_idle_cnt;
            o_stuck <= ~sync_val_ff | (nxt_idle_cnt == `GCS_STUCK_CYCLES);
        end
    end

endmodule // gcs_input_guard

`default_nettype wire

// file: rtl/gcs_top.v
/*
 * Glitchless two-input clock switch with fanout copies. Both clock
 * inputs are oversampled by the system clock; the switched clock is a
 * registered level driven to all copies.
 * Assumes clock inputs well below half the system rate, an external
 * loss-of-amplitude detector per input, and a power-on reset on I_SYS_RST.
 */
// Functional notes
// - Both inputs use identical guard and sequencing; either may be primary.
// - Bypass input makes a plain mux that switches at once.
// - Invalid selected input holds output at last valid level.
// - Running clocks: follow old briefly, low for new pulses, then follow new.
// - Old stuck high: high for new pulses, low for new falls, then new.
// - Extended cycle during stuck-high switch keeps both phases over half period.
// - Old stuck low: low for new falling edges, then follow new.
// - Dead old clock uses stuck sequence chosen by last valid level.
// - Floating or static selected input gives a stable output level.
// - Guard does not filter runts of a still toggling input.
// - Select is synchronised before use; stage lengths may vary.
// - New clock appears within 17 input cycles of a select change.
// - Power-on reset puts sequencing in a known state.
`timescale 1ns/1ns
`default_nettype none
`include "gcs_defines.vh"

module gcs_top (
    // System
    input wire I_CLK_SYS,
    input wire I_SYS_RST,
    // Clock sources and their valid flags
    input wire I_CLOCK_INPUT_A,
    input wire I_CLOCK_INPUT_B,
    input wire I_VALID_A,
    input wire I_VALID_B,
    // Control
    input wire I_SELECT,
    input wire I_BYPASS,
    // Outputs
    output wire [`GCS_FANOUT-1:0] O_CLK_OUT,
    output wire O_ACTIVE_SEL,
    output wire O_SWITCHING
);

    ////////////////////////////////////////////////////////////////////
    wire [1:0] raw_clk;
    wire [1:0] raw_valid;
    wire [1:0] lvl;
    wire [1:0] rise;
    wire [1:0] fall;
    wire [1:0] stuck;

    assign raw_clk = {I_CLOCK_INPUT_B, I_CLOCK_INPUT_A};
    assign raw_valid = {I_VALID_B, I_VALID_A};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_guard
            gcs_input_guard u_guard (
                .i_clk(I_CLK_SYS),
                .i_rst(I_SYS_RST),
                .i_clk_in(raw_clk[g]),
                .i_valid(raw_valid[g]),
                .o_level(lvl[g]),
                .o_rise(rise[g]),
                .o_fall(fall[g]),
                .o_stuck(stuck[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Select and bypass are pins: two flops before use
    reg sel_meta_ff;
    reg sel_sync_ff;
    reg byp_meta_ff;
    reg byp_sync_ff;

    always @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            sel_meta_ff <= 1'b0;
            sel_sync_ff <= 1'b0;
            byp_meta_ff <= 1'b0;
            byp_sync_ff <= 1'b0;
        end else begin
            sel_meta_ff <= I_SELECT;
            sel_sync_ff <= sel_meta_ff;
            byp_meta_ff <= I_BYPASS;
            byp_sync_ff <= byp_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg cur_ff;
    reg nxt_cur;
    reg tgt_ff;
    reg nxt_tgt;
    reg [2:0] cnt_ff;
    reg [2:0] nxt_cnt;
    reg out_ff;
    reg nxt_out;

    wire old_lvl;
    wire old_fall;
    wire old_stuck;
    wire new_rise;
    wire new_fall;

    assign old_lvl = lvl[cur_ff];
    assign old_fall = fall[cur_ff];
    assign old_stuck = stuck[cur_ff];
    assign new_rise = rise[tgt_ff];
    assign new_fall = fall[tgt_ff];

    // Stage counts are short so the full sequence fits 17 input cycles
    always @* begin
        nxt_state = state_ff;
        nxt_cur = cur_ff;
        nxt_tgt = tgt_ff;
        nxt_cnt = cnt_ff;
        nxt_out = out_ff;
        if (byp_sync_ff) begin
            // Plain mux: no staging at all
            nxt_state = `GCS_ST_FOLLOW;
            nxt_cur = sel_sync_ff;
            nxt_tgt = sel_sync_ff;
            nxt_cnt = 3'h0;
            nxt_out = lvl[sel_sync_ff];
        end else begin
            case (state_ff)
                `GCS_ST_FOLLOW: begin
                    nxt_out = old_lvl;
                    if (sel_sync_ff != cur_ff) begin
                        nxt_tgt = sel_sync_ff;
                        nxt_cnt = 3'h0;
                        if (!old_stuck) begin
                            nxt_state = `GCS_ST_DRAIN;
                        end else if (old_lvl) begin
                            nxt_state = `GCS_ST_HOLD_HI;
                            nxt_out = 1'b1;
                        end else begin
                            nxt_state = `GCS_ST_LOW;
                            nxt_out = 1'b0;
                        end
                    end
                end
                `GCS_ST_DRAIN: begin
                    nxt_out = old_lvl;
                    if (old_stuck) begin
                        // Old clock died mid-sequence
                        nxt_cnt = 3'h0;
                        nxt_state = old_lvl ? `GCS_ST_HOLD_HI : `GCS_ST_LOW;
                    end else if (old_fall) begin
                        if (cnt_ff == `GCS_STAGE1_PULSES - 3'h1) begin
                            nxt_cnt = 3'h0;
                            nxt_out = 1'b0;
                            nxt_state = `GCS_ST_LOW;
                        end else begin
                            nxt_cnt = cnt_ff + 3'h1;
                        end
                    end
                end
                `GCS_ST_HOLD_HI: begin
                    nxt_out = 1'b1;
                    if (new_rise && cnt_ff != `GCS_HIGH_PULSES) begin
                        nxt_cnt = cnt_ff + 3'h1;
                    end
                    // Drop only on a new falling edge: high phase over half period
                    if (new_fall && cnt_ff == `GCS_HIGH_PULSES) begin
                        nxt_cnt = 3'h0;
                        nxt_out = 1'b0;
                        nxt_state = `GCS_ST_LOW;
                    end
                end
                `GCS_ST_LOW: begin
                    nxt_out = 1'b0;
                    // At least one full new falling-edge interval low
                    if (new_fall) begin
                        if (cnt_ff == `GCS_LOW_EDGES - 3'h1) begin
                            nxt_cnt = 3'h0;
                            nxt_cur = tgt_ff;
                            nxt_state = `GCS_ST_FOLLOW;
                        end else begin
                            nxt_cnt = cnt_ff + 3'h1;
                        end
                    end
                end
                default: begin
                    nxt_state = `GCS_ST_FOLLOW;
                    nxt_cnt = 3'h0;
                    nxt_out = 1'b0;
                end
            endcase
        end
    end

    always @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state_ff <= `GCS_ST_FOLLOW;
            cur_ff <= 1'b0;
            tgt_ff <= 1'b0;
            cnt_ff <= 3'h0;
            out_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cur_ff <= nxt_cur;
            tgt_ff <= nxt_tgt;
            cnt_ff <= nxt_cnt;
            out_ff <= nxt_out;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One flop feeds every copy, so copies never disagree
    assign O_CLK_OUT = {`GCS_FANOUT{out_ff}};
    assign O_ACTIVE_SEL = cur_ff;
    assign O_SWITCHING = (state_ff != `GCS_ST_FOLLOW);

endmodule // gcs_top

`default_nettype wire
